// ---- design/bsarb_pkg.sv ----
// bsarb_pkg: shared types and constants of the bus ownership arbiter.
// assumes: nothing beyond a SystemVerilog compiler.
package bsarb_pkg;
    // ------------------------------------------------------------------
    // arbitration states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SNOOP,
        ST_IMPLICIT,
        ST_PARK,
        ST_ACTIVE
    } bsarb_state_t;

    // ------------------------------------------------------------------
    // line and timing constants
    // ------------------------------------------------------------------
    localparam int LINE_BEATS = 4;
    localparam logic [1:0] BEAT_LAST = 2'h3;
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam int CLK_PERIOD_NS = 50;
    localparam int OWNER_GAP_NS = 50;
    localparam int OWNER_GAP_CYC =
        (OWNER_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : bsarb_pkg

// ---- design/bsarb_sync.sv ----
// bsarb_sync: two-flop synchroniser for one pin level.
// assumes: one clock, synchronous active-low reset.
`timescale 1ns/1ns
module bsarb_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // synchronous reset, active low
    input wire logic pin_in, // asynchronous level
    output logic level_out // synchronised level
);
    logic meta_reg;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            meta_reg <= RESET_VAL;
            level_out <= RESET_VAL;
        end else begin
            meta_reg <= pin_in;
            level_out <= meta_reg;
        end
    end
endmodule : bsarb_sync

// ---- design/bsarb_top.sv ----
// bsarb_top: processor-side bus ownership arbitration unit.
// assumes: pins from the bus are asynchronous and are synchronised here;
// the access engine on clk_sys gives requests and line/lock flags.
`timescale 1ns/1ns
module bsarb_top (
    input wire logic clk_sys, // 20 MHz system clock
    input wire logic reset_n, // synchronous reset, active low
    input wire logic access_pending, // internal access waiting
    input wire logic access_line, // pending access is a four-beat line
    input wire logic access_lock_last, // pending access ends a lock
    input wire logic snoop_hit, // another master's cycle to snoop
    input wire logic bus_grant_n, // grant pin, active low
    input wire logic bus_busy_in_n, // busy pin level, active low
    input wire logic transfer_ack_n, // ack pin, active low
    input wire logic transfer_error_ack_n, // error ack pin, active low
    output logic bus_request_n, // request pin, active low
    output logic bus_busy_out_n, // busy drive value, active low
    output logic bus_busy_oe_n, // busy output enable, active low
    output logic transfer_start_n, // start pulse, active low
    output logic transfer_in_progress_n, // in-progress, active low
    output logic tip_oe_n, // in-progress enable, active low
    output logic rmw_final_write_n, // final locked write, active low
    output logic bus_oe_n, // address/control enable, active low
    output logic bus_data_valid, // bus carries defined values
    output logic cycle_done, // access completed, pulse
    output logic cycle_retry, // access must be retried, pulse
    output logic snooping // ready to service a snoop
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic grant_s, busy_free_s, ack_s, err_s;
    logic grant_raw, busy_raw, ack_raw, err_raw;

    bsarb_sync #(.RESET_VAL(1'b1)) u_sync_bg (
        .clk_sys(clk_sys), .reset_n(reset_n),
        .pin_in(bus_grant_n), .level_out(grant_raw));
    bsarb_sync #(.RESET_VAL(1'b1)) u_sync_bb (
        .clk_sys(clk_sys), .reset_n(reset_n),
        .pin_in(bus_busy_in_n), .level_out(busy_raw));
    bsarb_sync #(.RESET_VAL(1'b1)) u_sync_ta (
        .clk_sys(clk_sys), .reset_n(reset_n),
        .pin_in(transfer_ack_n), .level_out(ack_raw));
    bsarb_sync #(.RESET_VAL(1'b1)) u_sync_tea (
        .clk_sys(clk_sys), .reset_n(reset_n),
        .pin_in(transfer_error_ack_n), .level_out(err_raw));

    assign grant_s = !grant_raw;
    assign busy_free_s = busy_raw;
    assign ack_s = !ack_raw;
    assign err_s = !err_raw;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    bsarb_pkg::bsarb_state_t state_reg, state_next;
    logic [1:0] beat_reg;
    logic line_reg, lock_reg;
    logic term_any, term_retry, term_last;

    // a beat ends on either ack; both together means relinquish and retry
    assign term_any = ack_s || err_s;
    assign term_retry = ack_s && err_s;
    // a line holds ownership until its fourth beat
    assign term_last = term_any &&
        (term_retry || !line_reg || beat_reg == bsarb_pkg::BEAT_LAST);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            bsarb_pkg::ST_IDLE, bsarb_pkg::ST_SNOOP: begin
                // claim only once the other master freed busy
                if (grant_s && busy_free_s && access_pending) begin
                    state_next = bsarb_pkg::ST_ACTIVE;
                end else if (grant_s && busy_free_s) begin
                    state_next = bsarb_pkg::ST_IMPLICIT;
                end else if (snoop_hit) begin
                    state_next = bsarb_pkg::ST_SNOOP;
                end else begin
                    state_next = bsarb_pkg::ST_IDLE;
                end
            end
            bsarb_pkg::ST_IMPLICIT: begin
                if (!grant_s) begin
                    state_next = bsarb_pkg::ST_IDLE;
                end else if (access_pending) begin
                    state_next = bsarb_pkg::ST_ACTIVE;
                end
            end
            bsarb_pkg::ST_PARK: begin
                if (!grant_s) begin
                    state_next = bsarb_pkg::ST_IDLE;
                end else if (access_pending) begin
                    state_next = bsarb_pkg::ST_ACTIVE;
                end
            end
            bsarb_pkg::ST_ACTIVE: begin
                // grant loss only takes effect at cycle end
                if (term_last) begin
                    if (!grant_s || term_retry) begin
                        state_next = bsarb_pkg::ST_IDLE;
                    end else if (access_pending) begin
                        state_next = bsarb_pkg::ST_ACTIVE;
                    end else begin
                        state_next = bsarb_pkg::ST_PARK;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_reg <= bsarb_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // beat counter and latched attributes of the running access
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            beat_reg <= bsarb_pkg::BEAT_FIRST;
            line_reg <= 1'b0;
            lock_reg <= 1'b0;
        end else if (state_next == bsarb_pkg::ST_ACTIVE &&
                     (state_reg != bsarb_pkg::ST_ACTIVE || term_last)) begin
            beat_reg <= bsarb_pkg::BEAT_FIRST;
            line_reg <= access_line;
            lock_reg <= access_lock_last;
        end else if (state_reg == bsarb_pkg::ST_ACTIVE && term_any) begin
            beat_reg <= beat_reg + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all registered
    // ------------------------------------------------------------------
    logic start_next, owner_next, active_next;

    assign active_next = state_next == bsarb_pkg::ST_ACTIVE;
    assign start_next = active_next &&
        (state_reg != bsarb_pkg::ST_ACTIVE || term_last);
    assign owner_next = active_next || state_next == bsarb_pkg::ST_PARK ||
        state_next == bsarb_pkg::ST_IMPLICIT;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bus_request_n <= 1'b1;
        end else begin
            // registered follow of the pending request; the lock is not
            // held here so the arbiter may split read and write
            bus_request_n <= !access_pending;
        end
    end

    // request and start share the same clock from a granted state
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            transfer_start_n <= 1'b1;
            transfer_in_progress_n <= 1'b1;
            tip_oe_n <= 1'b1;
            rmw_final_write_n <= 1'b1;
        end else begin
            transfer_start_n <= !start_next;
            transfer_in_progress_n <= !active_next;
            // negated for one clock before release, then floated
            tip_oe_n <= !(active_next ||
                state_reg == bsarb_pkg::ST_ACTIVE);
            rmw_final_write_n <= !(active_next &&
                (start_next ? access_lock_last : lock_reg));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bus_busy_out_n <= 1'b1;
            bus_busy_oe_n <= 1'b1;
        end else begin
            // asserted in active and park, negated otherwise
            bus_busy_out_n <= !(active_next ||
                state_next == bsarb_pkg::ST_PARK);
            // an extra negated clock drives busy high before floating
            bus_busy_oe_n <= !(active_next ||
                state_next == bsarb_pkg::ST_PARK ||
                state_reg == bsarb_pkg::ST_ACTIVE ||
                state_reg == bsarb_pkg::ST_PARK);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bus_oe_n <= 1'b1;
            bus_data_valid <= 1'b0;
            snooping <= 1'b0;
            cycle_done <= 1'b0;
            cycle_retry <= 1'b0;
        end else begin
            bus_oe_n <= !owner_next;
            bus_data_valid <= active_next;
            snooping <= state_next == bsarb_pkg::ST_SNOOP;
            cycle_done <= state_reg == bsarb_pkg::ST_ACTIVE &&
                term_last && !term_retry;
            cycle_retry <= state_reg == bsarb_pkg::ST_ACTIVE &&
                term_retry;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence claim_s;
        !transfer_start_n && !bus_busy_out_n && !bus_busy_oe_n;
    endsequence

    req_follows_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        access_pending |=> !bus_request_n)
        else $error("request did not follow pending access");

    req_drops_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        !access_pending |=> bus_request_n)
        else $error("request held with nothing pending");

    idle_float_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        state_reg == bsarb_pkg::ST_IDLE |-> bus_busy_oe_n || bus_busy_out_n)
        else $error("busy asserted while idle");

    implicit_float_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        state_reg == bsarb_pkg::ST_IMPLICIT
        |-> bus_busy_oe_n && !bus_oe_n && transfer_in_progress_n)
        else $error("implicit ownership drove busy or ran a cycle");

    active_drive_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        !transfer_in_progress_n |-> !bus_busy_out_n && bus_data_valid)
        else $error("active cycle without busy");

    start_claim_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        !transfer_start_n |-> claim_s)
        else $error("start without busy claim");

    busy_negate_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        !bus_busy_oe_n && !bus_busy_out_n |=> !bus_busy_oe_n)
        else $error("busy floated without being negated first");

    line_hold_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        state_reg == bsarb_pkg::ST_ACTIVE && line_reg && !term_retry &&
        beat_reg != bsarb_pkg::BEAT_LAST |=> !transfer_in_progress_n)
        else $error("line released early");

    grant_finish_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        state_reg == bsarb_pkg::ST_ACTIVE && !grant_s && !term_any
        |=> state_reg == bsarb_pkg::ST_ACTIVE)
        else $error("cycle abandoned on grant loss");

    park_entry_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        state_reg != bsarb_pkg::ST_PARK &&
        state_next == bsarb_pkg::ST_PARK
        |-> state_reg == bsarb_pkg::ST_ACTIVE && term_last)
        else $error("park without completed cycle");

    park_exit_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        state_reg == bsarb_pkg::ST_PARK && grant_s && access_pending
        |=> !transfer_start_n && !transfer_in_progress_n && !bus_request_n)
        else $error("park exit not simultaneous");

    retry_rel_a: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        state_reg == bsarb_pkg::ST_ACTIVE && term_retry
        |=> cycle_retry && bus_oe_n)
        else $error("retry did not release");
endmodule : bsarb_top

// ---- tb/bsarb_arbiter_model.sv ----
// bsarb_arbiter_model: external arbiter, alternate master and slave acks.
// assumes: the bench steers grant, alternate busy, beats and wait states.
`timescale 1ns/1ns
module bsarb_arbiter_model (
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // sync reset, active low
    input wire logic grant_on, // bench: grant the device
    input wire logic alt_busy, // bench: alternate master holds busy
    input wire logic [2:0] beats, // acks per access
    input wire logic [1:0] wait_cyc, // wait states per beat, at least 1
    input wire logic retry, // end the next access with both acks
    input wire logic transfer_start_n, // device start
    input wire logic bus_busy_out_n, // device busy value
    input wire logic bus_busy_oe_n, // device busy enable
    output logic bus_grant_n, // grant pin
    output logic bus_busy_in_n, // resolved busy wire
    output logic transfer_ack_n, // ack pin
    output logic transfer_error_ack_n // error ack pin
);
    logic [2:0] left_reg;
    logic [1:0] cnt_reg;
    // pulled-up wire: low only while some master drives it low
    assign bus_busy_in_n = !((!bus_busy_oe_n && !bus_busy_out_n) || alt_busy);
    always_ff @(posedge clk_sys) begin
        bus_grant_n <= !(grant_on && reset_n);
    end
    always_ff @(posedge clk_sys) begin
        transfer_ack_n <= 1'b1;
        transfer_error_ack_n <= 1'b1;
        if (!reset_n) begin
            left_reg <= 3'h0;
            cnt_reg <= 2'h0;
        end else if (transfer_start_n == 1'b0) begin
            left_reg <= retry ? 3'h1 : beats;
            cnt_reg <= wait_cyc;
        end else if (left_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 2'h1;
            if (cnt_reg == 2'h0) begin
                // one-cycle pulses with a gap, so each beat is seen once
                transfer_ack_n <= 1'b0;
                transfer_error_ack_n <= !retry;
                left_reg <= left_reg - 3'h1;
                cnt_reg <= wait_cyc;
            end
        end
    end
endmodule : bsarb_arbiter_model

// ---- tb/test_bus_ownership_arbitration.sv ----
// test_bus_ownership_arbitration: self-checking bench of bsarb_top.
// assumes: bsarb_arbiter_model stands for the arbiter and far bus.
`timescale 1ns/1ns
module test_bus_ownership_arbitration;
    logic clk_sys, reset_n, access_pending, access_line, access_lock_last;
    logic snoop_hit, bus_grant_n, bus_busy_in_n, transfer_ack_n;
    logic transfer_error_ack_n, bus_request_n, bus_busy_out_n, bus_busy_oe_n;
    logic transfer_start_n, transfer_in_progress_n, tip_oe_n;
    logic rmw_final_write_n, bus_oe_n, bus_data_valid, cycle_done;
    logic cycle_retry, snooping, grant_on, alt_busy, retry;
    logic [2:0] beats;
    logic [1:0] wait_cyc;
    int mismatches = 0;
    int cmp_count = 0;
    int seed = 95413;

    bsarb_top i_bsarb_top (.clk_sys(clk_sys), .reset_n(reset_n),
        .access_pending(access_pending), .access_line(access_line),
        .access_lock_last(access_lock_last), .snoop_hit(snoop_hit),
        .bus_grant_n(bus_grant_n), .bus_busy_in_n(bus_busy_in_n),
        .transfer_ack_n(transfer_ack_n),
        .transfer_error_ack_n(transfer_error_ack_n),
        .bus_request_n(bus_request_n), .bus_busy_out_n(bus_busy_out_n),
        .bus_busy_oe_n(bus_busy_oe_n), .transfer_start_n(transfer_start_n),
        .transfer_in_progress_n(transfer_in_progress_n), .tip_oe_n(tip_oe_n),
        .rmw_final_write_n(rmw_final_write_n), .bus_oe_n(bus_oe_n),
        .bus_data_valid(bus_data_valid), .cycle_done(cycle_done),
        .cycle_retry(cycle_retry), .snooping(snooping));
    bsarb_arbiter_model i_bsarb_arbiter_model (.clk_sys(clk_sys),
        .reset_n(reset_n), .grant_on(grant_on), .alt_busy(alt_busy),
        .beats(beats), .wait_cyc(wait_cyc), .retry(retry),
        .transfer_start_n(transfer_start_n), .bus_busy_out_n(bus_busy_out_n),
        .bus_busy_oe_n(bus_busy_oe_n), .bus_grant_n(bus_grant_n),
        .bus_busy_in_n(bus_busy_in_n), .transfer_ack_n(transfer_ack_n),
        .transfer_error_ack_n(transfer_error_ack_n));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize

    task automatic chk(input bit ok, input string msg);
        cmp_count++;
        if (!ok) begin
            mismatches++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk

    // acks the far side must give for one access
    function automatic logic [2:0] exp_beats(input logic line);
        return line ? 3'(bsarb_pkg::LINE_BEATS) : 3'h1;
    endfunction : exp_beats

    task automatic idle_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : idle_n

    // one access; drop takes the grant away once the cycle has begun
    task automatic run_access(input logic line, input logic lock,
        input logic rty, input logic drop);
        int n;
        int acks;
        @(posedge clk_sys);
        access_line <= line;
        access_lock_last <= lock;
        access_pending <= 1'b1;
        beats <= exp_beats(line);
        retry <= rty;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
            if (n == 2)
                chk(bus_request_n === 1'b0, "no request");
        end while (transfer_start_n !== 1'b0 && n < 60);
        chk(n < 60, "start timeout");
        chk(bus_request_n === 1'b0 &&
            bus_busy_out_n === 1'b0 && bus_busy_oe_n === 1'b0,
            "start without request or busy");
        chk(transfer_in_progress_n === 1'b0 && tip_oe_n === 1'b0 &&
            bus_data_valid === 1'b1 && bus_oe_n === 1'b0, "not active");
        chk(rmw_final_write_n === !lock, "final write flag");
        n = 0;
        acks = 0;
        do begin
            @(posedge clk_sys);
            if (drop) grant_on <= 1'b0;
            if (acks == beats && !rty) access_pending <= 1'b0;
            @(negedge clk_sys);
            n++;
            if (transfer_ack_n === 1'b0) acks++;
            if (cycle_done !== 1'b1 && cycle_retry !== 1'b1)
                chk(bus_busy_out_n === 1'b0 && bus_busy_oe_n === 1'b0,
                    "busy lost mid-cycle");
        end while (cycle_done !== 1'b1 && cycle_retry !== 1'b1 && n < 200);
        chk(acks == int'(beats), "ended before all beats");
        chk((rty ? cycle_retry : cycle_done) === 1'b1,
            "wrong ending");
    endtask : run_access

    task automatic check_release();
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while ((bus_busy_oe_n !== 1'b1 || bus_oe_n !== 1'b1) && n < 12);
        chk(n < 12, "bus not released");
    endtask : check_release

    initial begin
        reset_n = 1'b0;
        {access_pending, access_line, access_lock_last, snoop_hit} = 4'h0;
        {grant_on, alt_busy, retry} = 3'h0;
        beats = 3'h1;
        wait_cyc = 2'h1;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        idle_n(2);
        chk(bus_request_n === 1'b1 &&
            bus_busy_oe_n === 1'b1 && bus_oe_n === 1'b1 &&
            tip_oe_n === 1'b1, "reset state");
        $display("test reset done");
        @(posedge clk_sys) snoop_hit <= 1'b1;
        idle_n(4);
        chk(snooping === 1'b1 && bus_oe_n === 1'b1 &&
            bus_busy_oe_n === 1'b1, "snoop drive");
        @(posedge clk_sys) snoop_hit <= 1'b0;
        grant_on <= 1'b1;
        idle_n(6);
        chk(bus_oe_n === 1'b0 && bus_busy_oe_n === 1'b1 &&
            transfer_start_n === 1'b1, "implicit ownership");
        run_access(1'b0, 1'b0, 1'b0, 1'b0);
        idle_n(4);
        chk(bus_busy_oe_n === 1'b0 && bus_busy_out_n === 1'b0 &&
            transfer_in_progress_n === 1'b1, "not parked");
        chk(bus_request_n === 1'b1, "request kept");
        $display("test implicit and park done");
        run_access(1'b1, 1'b0, 1'b0, 1'b0);
        run_access(1'b0, 1'b1, 1'b0, 1'b0);
        run_access(1'b1, 1'b0, 1'b0, 1'b1);
        check_release();
        $display("test line and grant loss done");
        @(posedge clk_sys) grant_on <= 1'b1;
        run_access(1'b0, 1'b0, 1'b1, 1'b1);
        check_release();
        @(posedge clk_sys) alt_busy <= 1'b1;
        retry <= 1'b0;
        grant_on <= 1'b1;
        idle_n(10);
        chk(transfer_start_n === 1'b1 && bus_busy_oe_n === 1'b1,
            "started over alternate master");
        @(posedge clk_sys) alt_busy <= 1'b0;
        run_access(1'b0, 1'b0, 1'b0, 1'b0);
        $display("test retry and busy wait done");
        repeat (12) begin
            @(posedge clk_sys);
            wait_cyc <= 2'h1 + 2'($unsigned($random(seed)) % 3);
            run_access(1'($random(seed)), 1'($random(seed)),
                1'b0, 1'b0);
        end
        $display("test random done");
        // grant taken away while parked: busy negated, then floated
        @(posedge clk_sys) grant_on <= 1'b0;
        check_release();
        chk(bus_busy_out_n === 1'b1 &&
            snooping === 1'b0, "park release");
        $display("test park release done");
        summarize();
    end
endmodule : test_bus_ownership_arbitration
